// ===== design/pes_defs.svh
// Purpose: constants for the event enable and page select block
// Assumes: 5-bit management register addresses, 16-bit register data
// Notes: included by the package, the page decoder and the event controller; the sticky flag does not include it
//
// How it works
// - Selectors 8:7 both zero: status bit 8 flags rx-error half-full, clear on read.
// - Either selector 8:7 set: status bit 8 flags control frame, clear on read.
// - Bit 7 enables link quality monitor interrupt, resets to zero.
// - Bit 6 enables energy detect interrupt, resets to zero.
// - Bit 5 enables link status change interrupt, resets to zero.
// - Bit 4 enables speed change interrupt, resets to zero.
// - Bit 3 enables duplex change, or time protocol when control bit 3 set.
// - Bit 2 enables auto-negotiation complete interrupt, resets to zero.
// - Bit 1 enables false-carrier half-full, or either counter half-full.
// - Bit 0 enables rx-error half-full, or control frame event.
// - Page select bits 15:3 ignore writes and read zero.
// - Three-bit page field, reset zero, picks bank for addresses 14h to 1Fh.
// - Page 0 ext zero, 2 diagnostics, 4 time base, 5/6 time config.
// - Time protocol interrupt re-arms only once its status shows nothing waiting.
`ifndef PES_DEFS_SVH
`define PES_DEFS_SVH

`define PES_ADDR_ISEC 5'h12
`define PES_ADDR_PAGE 5'h13
`define PES_WIN_LO 5'h14
`define PES_WIN_HI 5'h1f

`define PES_STAT_BIT 8
`define PES_EN_W 8
`define PES_EN_RST 8'h00
`define PES_EN_LQ 7
`define PES_EN_ED 6
`define PES_EN_LINK 5
`define PES_EN_SPD 4
`define PES_EN_DUP 3
`define PES_EN_ANC 2
`define PES_EN_FHF 1
`define PES_EN_RHF 0

`define PES_PAGE_W 3
`define PES_PAGE_RST 3'h0
`define PES_PAGE_EXT0 3'h0
`define PES_PAGE_DIAG 3'h2
`define PES_PAGE_PTPB 3'h4
`define PES_PAGE_PTPC5 3'h5
`define PES_PAGE_PTPC6 3'h6

`endif

// ===== design/pes_pkg.sv
// Purpose: types shared by the event enable and page select block
// Assumes: pes_defs.svh holds the numbers
// Notes: nothing here is imported; users write pes_pkg::name
`include "pes_defs.svh"

package pes_pkg;

  // one management access, valid for one cycle while req is high
  typedef struct packed {
    logic req;
    logic write;
    logic [4:0] addr;
    logic [15:0] wdata;
  } pes_mgmt_s;

  // one-cycle event pulses from the phy core, same clock
  typedef struct packed {
    logic link_quality;
    logic energy;
    logic link;
    logic speed;
    logic duplex;
    logic ptp;
    logic autoneg;
    logic false_carrier_hf;
    logic rx_err_hf;
    logic ctrl_frame;
  } pes_evt_s;

  typedef enum logic [4:0] {
    PES_BANK_NONE = 5'b00001,
    PES_BANK_EXT0 = 5'b00010,
    PES_BANK_DIAG = 5'b00100,
    PES_BANK_PTPB = 5'b01000,
    PES_BANK_PTPC = 5'b10000
  } pes_bank_e;

  typedef enum logic [1:0] {
    PES_PTP_ARMED = 2'b01,
    PES_PTP_HELD = 2'b10
  } pes_ptp_e;

  function automatic logic pes_in_window(input logic [4:0] addr);
    pes_in_window = (addr >= `PES_WIN_LO) && (addr <= `PES_WIN_HI);
  endfunction : pes_in_window

endpackage : pes_pkg

// ===== design/pes_sticky.sv
// Purpose: one clear-on-read pending flag
// Assumes: set and clear are single-cycle strobes on clk_sys
// Notes: a set in the clearing cycle survives the clear
module pes_sticky (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic set,
  input wire logic clear,
  output logic flag
);

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      flag <= 1'b0;
    end else if (set) begin
      flag <= 1'b1;
    end else if (clear) begin
      flag <= 1'b0;
    end
  end

endmodule : pes_sticky

// ===== design/pes_page_dec.sv
// Purpose: decode the page field and address into a paged bank select
// Assumes: page is the registered page field
// Notes: reserved page values select no bank
`include "pes_defs.svh"

module pes_page_dec (
  input wire logic [2:0] page,
  input wire logic [4:0] addr,
  output pes_pkg::pes_bank_e bank,
  output logic window_hit
);

  assign window_hit = pes_pkg::pes_in_window(addr);

  always_comb begin
    case (page)
      `PES_PAGE_EXT0: bank = pes_pkg::PES_BANK_EXT0;
      `PES_PAGE_DIAG: bank = pes_pkg::PES_BANK_DIAG;
      `PES_PAGE_PTPB: bank = pes_pkg::PES_BANK_PTPB;
      `PES_PAGE_PTPC5: bank = pes_pkg::PES_BANK_PTPC;
      `PES_PAGE_PTPC6: bank = pes_pkg::PES_BANK_PTPC;
      // 1, 3 and 7 are left unmapped; software keeps off them
      default: bank = pes_pkg::PES_BANK_NONE;
    endcase
  end

endmodule : pes_page_dec

// ===== design/pes_event_ctrl.sv
// Purpose: status bit 8, interrupt enables 7:0 and the page select register
// Assumes: management accesses and events are synchronous to clk_sys
// Notes: status bits 15:9 live elsewhere and read as zero from here
`include "pes_defs.svh"

module pes_event_ctrl (
  input wire logic clk_sys,
  input wire logic rst,
  input pes_pkg::pes_mgmt_s mgmt,
  output logic mgmt_ack,
  output logic [15:0] mgmt_rdata,
  input wire logic [1:0] second_phy_control_sel,
  input wire logic [1:0] ctrl_frame_config_sel,
  input wire logic interrupt_control_ptp_sel,
  input wire logic time_protocol_status_empty,
  input pes_pkg::pes_evt_s evt,
  output logic irq_event,
  output logic [7:0] irq_enable,
  output logic [2:0] page_select,
  output pes_pkg::pes_bank_e page_bank,
  output logic page_window_hit
);

  // ----------------------------------------------------------------
  // access decode
  // ----------------------------------------------------------------
  logic wr_isec;
  logic wr_page;
  logic rd_isec;
  logic stat_sel_cf;
  logic en_sel_cf;
  logic set_pending;
  logic pending;
  logic ptp_armed;
  logic next_irq;
  pes_pkg::pes_ptp_e ptp_state;

  assign wr_isec = mgmt.req && mgmt.write && (mgmt.addr == `PES_ADDR_ISEC);
  assign wr_page = mgmt.req && mgmt.write && (mgmt.addr == `PES_ADDR_PAGE);
  assign rd_isec = mgmt.req && !mgmt.write && (mgmt.addr == `PES_ADDR_ISEC);
  assign stat_sel_cf = |second_phy_control_sel;
  assign en_sel_cf = |ctrl_frame_config_sel;

  // ----------------------------------------------------------------
  // status bit 8
  // ----------------------------------------------------------------
  // the flag follows its sources whether or not the enable is set
  assign set_pending = stat_sel_cf ? evt.ctrl_frame : evt.rx_err_hf;

  pes_sticky u_pending (
    .clk_sys(clk_sys),
    .rst(rst),
    .set(set_pending),
    .clear(rd_isec),
    .flag(pending)
  );

  // ----------------------------------------------------------------
  // enable and page registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      irq_enable <= `PES_EN_RST;
    end else if (wr_isec) begin
      irq_enable <= mgmt.wdata[`PES_EN_W-1:0];
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      page_select <= `PES_PAGE_RST;
    end else if (wr_page) begin
      page_select <= mgmt.wdata[`PES_PAGE_W-1:0]; // upper bits dropped
    end
  end

  pes_page_dec u_page_dec (
    .page(page_select),
    .addr(mgmt.addr),
    .bank(page_bank),
    .window_hit(page_window_hit)
  );

  // ----------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------
  // read data show the flag before this access clears it
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      mgmt_ack <= 1'b0;
      mgmt_rdata <= 16'h0000;
    end else begin
      mgmt_ack <= mgmt.req;
      if (mgmt.req && !mgmt.write && mgmt.addr == `PES_ADDR_ISEC) begin
        mgmt_rdata <= {7'h00, pending, irq_enable};
      end else if (mgmt.req && !mgmt.write && mgmt.addr == `PES_ADDR_PAGE) begin
        mgmt_rdata <= {13'h0000, page_select};
      end else begin
        mgmt_rdata <= 16'h0000;
      end
    end
  end

  // ----------------------------------------------------------------
  // time protocol re-arm
  // ----------------------------------------------------------------
  // one event per batch of status; avoids an interrupt storm while software drains
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ptp_state <= pes_pkg::PES_PTP_ARMED;
    end else begin
      case (ptp_state)
        pes_pkg::PES_PTP_ARMED: begin
          if (interrupt_control_ptp_sel && irq_enable[`PES_EN_DUP] && evt.ptp) begin
            ptp_state <= pes_pkg::PES_PTP_HELD;
          end
        end
        pes_pkg::PES_PTP_HELD: begin
          if (time_protocol_status_empty) begin
            ptp_state <= pes_pkg::PES_PTP_ARMED;
          end
        end
        default: ptp_state <= pes_pkg::PES_PTP_ARMED;
      endcase
    end
  end

  assign ptp_armed = (ptp_state == pes_pkg::PES_PTP_ARMED);

  // ----------------------------------------------------------------
  // interrupt request
  // ----------------------------------------------------------------
  always_comb begin
    next_irq = 1'b0;
    next_irq = next_irq | (irq_enable[`PES_EN_LQ] & evt.link_quality);
    next_irq = next_irq | (irq_enable[`PES_EN_ED] & evt.energy);
    next_irq = next_irq | (irq_enable[`PES_EN_LINK] & evt.link);
    next_irq = next_irq | (irq_enable[`PES_EN_SPD] & evt.speed);
    if (interrupt_control_ptp_sel) begin
      next_irq = next_irq | (irq_enable[`PES_EN_DUP] & evt.ptp & ptp_armed);
    end else begin
      next_irq = next_irq | (irq_enable[`PES_EN_DUP] & evt.duplex);
    end
    next_irq = next_irq | (irq_enable[`PES_EN_ANC] & evt.autoneg);
    if (en_sel_cf) begin
      next_irq = next_irq | (irq_enable[`PES_EN_FHF] & (evt.false_carrier_hf | evt.rx_err_hf));
      next_irq = next_irq | (irq_enable[`PES_EN_RHF] & evt.ctrl_frame);
    end else begin
      next_irq = next_irq | (irq_enable[`PES_EN_FHF] & evt.false_carrier_hf);
      next_irq = next_irq | (irq_enable[`PES_EN_RHF] & evt.rx_err_hf);
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      irq_event <= 1'b0;
    end else begin
      irq_event <= next_irq;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  a_status_cor: assert property (
    rd_isec && !set_pending |=> !pending
  ) else $error("status bit 8 not cleared by read");

  a_status_rx_err: assert property (
    !stat_sel_cf && evt.rx_err_hf |=> pending ##1 (pending || $past(rd_isec))
  ) else $error("rx error half-full not flagged");

  a_status_frame: assert property (
    stat_sel_cf && evt.ctrl_frame |=> pending
  ) else $error("control frame not flagged");

  a_status_quiet: assert property (
    stat_sel_cf && !evt.ctrl_frame && !pending |=> !pending
  ) else $error("status bit 8 set without its selected source");

  a_read_status: assert property (
    rd_isec |=> mgmt_ack && mgmt_rdata[`PES_STAT_BIT] == $past(pending)
  ) else $error("read data do not show the flag before clear");

  a_enable_write: assert property (
    wr_isec |=> irq_enable == $past(mgmt.wdata[7:0]) && $stable(page_select)
  ) else $error("enable write not stored");

  a_page_zero_hi: assert property (
    mgmt.req && !mgmt.write && mgmt.addr == `PES_ADDR_PAGE |=> mgmt_rdata[15:3] == 13'h0000
  ) else $error("page select upper bits not zero");

  a_page_write: assert property (
    wr_page |=> page_select == $past(mgmt.wdata[2:0]) ##1 $stable(page_select) || $past(wr_page)
  ) else $error("page field write not stored");

  a_bank_map: assert property (
    page_select == `PES_PAGE_PTPB |-> page_bank == pes_pkg::PES_BANK_PTPB
  ) else $error("page 4 does not select time base bank");

  a_ptp_hold: assert property (
    ptp_state == pes_pkg::PES_PTP_HELD && !time_protocol_status_empty |=>
      ptp_state == pes_pkg::PES_PTP_HELD
  ) else $error("time protocol interrupt re-armed early");

  a_duplex_path: assert property (
    !interrupt_control_ptp_sel && irq_enable[`PES_EN_DUP] && evt.duplex |=> irq_event
  ) else $error("duplex change did not raise interrupt");

  a_frame_path: assert property (
    en_sel_cf && irq_enable == 8'h01 && !evt.ctrl_frame |=> !irq_event
  ) else $error("bit 0 raised interrupt without control frame");

  // ----------------------------------------------------------------
  // checks on every enable path, the registers and the page decode
  // ----------------------------------------------------------------
  a_quality_path: assert property (
    irq_enable[`PES_EN_LQ] && evt.link_quality |=> irq_event
  ) else $error("link quality event did not raise interrupt");

  a_energy_path: assert property (
    irq_enable[`PES_EN_ED] && evt.energy |=> irq_event
  ) else $error("energy detect event did not raise interrupt");

  a_link_path: assert property (
    irq_enable[`PES_EN_LINK] && evt.link |=> irq_event
  ) else $error("link status change did not raise interrupt");

  a_speed_path: assert property (
    irq_enable[`PES_EN_SPD] && evt.speed |=> irq_event
  ) else $error("speed change did not raise interrupt");

  a_autoneg_path: assert property (
    irq_enable[`PES_EN_ANC] && evt.autoneg |=> irq_event
  ) else $error("auto-negotiation complete did not raise interrupt");

  a_irq_quiet: assert property (
    irq_enable == 8'h00 |=> !irq_event
  ) else $error("interrupt raised with every enable clear");

  a_ptp_path: assert property (
    interrupt_control_ptp_sel && irq_enable[`PES_EN_DUP] && evt.ptp &&
      ptp_state == pes_pkg::PES_PTP_ARMED |=> irq_event
  ) else $error("armed time protocol event did not raise interrupt");

  a_ptp_held_quiet: assert property (
    interrupt_control_ptp_sel && irq_enable == 8'h08 &&
      ptp_state == pes_pkg::PES_PTP_HELD |=> !irq_event
  ) else $error("held time protocol event raised interrupt");

  a_duplex_ignored: assert property (
    interrupt_control_ptp_sel && irq_enable == 8'h08 && !evt.ptp |=> !irq_event
  ) else $error("bit 3 raised interrupt without time protocol event");

  a_ptp_ignored: assert property (
    !interrupt_control_ptp_sel && irq_enable == 8'h08 && !evt.duplex |=> !irq_event
  ) else $error("bit 3 raised interrupt without duplex change");

  a_carrier_plain: assert property (
    !en_sel_cf && irq_enable[`PES_EN_FHF] && evt.false_carrier_hf |=> irq_event
  ) else $error("false carrier half-full did not raise interrupt");

  a_counter_alt: assert property (
    en_sel_cf && irq_enable[`PES_EN_FHF] &&
      (evt.false_carrier_hf || evt.rx_err_hf) |=> irq_event
  ) else $error("counter half-full did not raise interrupt");

  a_carrier_quiet: assert property (
    !en_sel_cf && irq_enable == 8'h02 && !evt.false_carrier_hf |=> !irq_event
  ) else $error("bit 1 raised interrupt without false carrier event");

  a_rx_err_plain: assert property (
    !en_sel_cf && irq_enable[`PES_EN_RHF] && evt.rx_err_hf |=> irq_event
  ) else $error("rx error half-full did not raise interrupt");

  a_frame_irq: assert property (
    en_sel_cf && irq_enable[`PES_EN_RHF] && evt.ctrl_frame |=> irq_event
  ) else $error("control frame did not raise interrupt");

  a_enable_hold: assert property (
    !wr_isec |=> $stable(irq_enable)
  ) else $error("enables changed without a write");

  a_page_hold: assert property (
    !wr_page |=> $stable(page_select)
  ) else $error("page field changed without a write");

  a_page_read: assert property (
    mgmt.req && !mgmt.write && mgmt.addr == `PES_ADDR_PAGE |=>
      mgmt_rdata == {13'h0, $past(page_select)}
  ) else $error("page select read data wrong");

  a_bank_ext0: assert property (
    page_select == `PES_PAGE_EXT0 |-> page_bank == pes_pkg::PES_BANK_EXT0
  ) else $error("page 0 does not select extended bank");

  a_bank_diag: assert property (
    page_select == `PES_PAGE_DIAG |-> page_bank == pes_pkg::PES_BANK_DIAG
  ) else $error("page 2 does not select diagnostics bank");

  a_bank_config: assert property (
    page_select == `PES_PAGE_PTPC5 || page_select == `PES_PAGE_PTPC6 |->
      page_bank == pes_pkg::PES_BANK_PTPC
  ) else $error("pages 5 and 6 do not select time config bank");

  a_window_hit: assert property (
    page_window_hit == (mgmt.addr[4] && mgmt.addr[3:2] != 2'b00)
  ) else $error("paged window hit wrong for address");

endmodule : pes_event_ctrl

// ===== test/pes_mgmt_host.sv
// Purpose: station management side model for the event control block
// Assumes: one-cycle request pulse, answer on the following edge
// Notes: released address and data are inverted so stale values never look valid
module pes_mgmt_host (
  input wire logic clk_sys,
  output pes_pkg::pes_mgmt_s mgmt,
  input wire logic mgmt_ack,
  input wire logic [15:0] mgmt_rdata,
  input wire logic window_hit
);
  timeunit 1ns;
  timeprecision 1ps;

  initial mgmt = '0;

  // --------------------------------
  // one access, launched at a falling edge
  // --------------------------------
  task automatic access(input logic wr, input logic [4:0] addr, input logic [15:0] wdata,
                        output logic [15:0] rdata, output logic ack, output logic hit);
    @(negedge clk_sys);
    mgmt.req = 1'b1;
    mgmt.write = wr;
    mgmt.addr = addr;
    mgmt.wdata = wdata;
    @(posedge clk_sys);
    hit = window_hit;
    @(negedge clk_sys);
    ack = mgmt_ack;
    rdata = mgmt_rdata;
    mgmt.req = 1'b0;
    mgmt.addr = ~mgmt.addr;
    mgmt.wdata = ~mgmt.wdata;
  endtask : access
endmodule : pes_mgmt_host

// ===== test/test_phy_event_enable_and_page_select.sv
// Purpose: self-checking bench for the event enable and page select block
// Assumes: inputs change at the falling edge, outputs read at the next falling edge
// Notes: page writes stay on the documented values only
module test_phy_event_enable_and_page_select;
  timeunit 1ns;
  timeprecision 1ps;

  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  pes_pkg::pes_mgmt_s mgmt;
  logic mgmt_ack;
  logic [15:0] mgmt_rdata;
  logic [1:0] spc_sel = 2'h0;
  logic [1:0] cfg_sel = 2'h0;
  logic ptp_sel = 1'b0;
  logic ts_empty = 1'b0;
  pes_pkg::pes_evt_s evt = '0;
  logic irq_event;
  logic [7:0] irq_enable;
  logic [2:0] page_select;
  pes_pkg::pes_bank_e page_bank;
  logic page_window_hit;
  int err_count = 0;
  int n_checks = 0;
  logic [15:0] rd;
  logic ak;
  logic ht;
  logic [2:0] pg [5] = '{3'h0, 3'h2, 3'h4, 3'h5, 3'h6};
  pes_pkg::pes_bank_e bk [5] = '{pes_pkg::PES_BANK_EXT0, pes_pkg::PES_BANK_DIAG,
    pes_pkg::PES_BANK_PTPB, pes_pkg::PES_BANK_PTPC, pes_pkg::PES_BANK_PTPC};

  always #12.5 clk_sys = ~clk_sys;

  pes_event_ctrl DUT (
    .clk_sys(clk_sys),
    .rst(rst),
    .mgmt(mgmt),
    .mgmt_ack(mgmt_ack),
    .mgmt_rdata(mgmt_rdata),
    .second_phy_control_sel(spc_sel),
    .ctrl_frame_config_sel(cfg_sel),
    .interrupt_control_ptp_sel(ptp_sel),
    .time_protocol_status_empty(ts_empty),
    .evt(evt),
    .irq_event(irq_event),
    .irq_enable(irq_enable),
    .page_select(page_select),
    .page_bank(page_bank),
    .page_window_hit(page_window_hit)
  );

  pes_mgmt_host host (
    .clk_sys(clk_sys),
    .mgmt(mgmt),
    .mgmt_ack(mgmt_ack),
    .mgmt_rdata(mgmt_rdata),
    .window_hit(page_window_hit)
  );

  // --------------------------------
  // helpers
  // --------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic report_and_stop();
    if (err_count == 0 && n_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : report_and_stop

  task automatic wr(input logic [4:0] addr, input logic [15:0] data);
    host.access(1'b1, addr, data, rd, ak, ht);
    check({15'h0, ak}, 16'h0001);
    check(rd, 16'h0000);
  endtask : wr

  task automatic rd_chk(input logic [4:0] addr, input logic [15:0] exp);
    host.access(1'b0, addr, 16'h0000, rd, ak, ht);
    check({15'h0, ak}, 16'h0001);
    check(rd, exp);
  endtask : rd_chk

  // which event index j (msb link_quality = 9) each enable bit i lets through
  function automatic logic fires(input int i, input int j, input logic alt, input logic ptp);
    int m [8] = '{1, 2, 3, 5, 6, 7, 8, 9};
    if (ptp && i == 3) return j == 4;
    if (alt && i == 1) return j == 2 || j == 1;
    if (alt && i == 0) return j == 0;
    return j == m[i];
  endfunction : fires

  task automatic pulse(input int j, input logic exp);
    @(negedge clk_sys);
    evt = pes_pkg::pes_evt_s'(10'h1 << j);
    @(negedge clk_sys);
    evt = '0;
    check({15'h0, irq_event}, {15'h0, exp});
  endtask : pulse

  task automatic rearm();
    @(negedge clk_sys);
    ts_empty = 1'b1;
    @(negedge clk_sys);
    ts_empty = 1'b0;
  endtask : rearm

  // --------------------------------
  // tests
  // --------------------------------
  initial begin
    repeat (4) @(posedge clk_sys);
    @(negedge clk_sys);
    rst = 1'b0;
    rd_chk(5'h12, 16'h0000);
    rd_chk(5'h13, 16'h0000);
    check(16'(page_bank), 16'(pes_pkg::PES_BANK_EXT0));
    wr(5'h12, 16'hffff);
    rd_chk(5'h12, 16'h00ff);
    check(16'(irq_enable), 16'h00ff);
    wr(5'h13, 16'hfffc);
    rd_chk(5'h13, 16'h0004);
    // page values 1, 3 and 7 are never written from this side
    for (int k = 0; k < 5; k++) begin
      wr(5'h13, {13'h1fff, pg[k]});
      check(16'(page_select), 16'(pg[k]));
      check(16'(page_bank), 16'(bk[k]));
    end
    rd_chk(5'h14, 16'h0000);
    check({15'h0, ht}, 16'h0001);
    rd_chk(5'h1f, 16'h0000);
    check({15'h0, ht}, 16'h0001);
    rd_chk(5'h11, 16'h0000);
    check({15'h0, ht}, 16'h0000);
    // every enable against every event, plain and alternate meanings
    for (int a = 0; a < 4; a++) begin
      @(negedge clk_sys);
      cfg_sel = 2'(a);
      ptp_sel = (a > 1);
      rearm();
      for (int i = 0; i < 8; i++) begin
        wr(5'h12, 16'hff00 | (16'h1 << i));
        for (int j = 0; j < 10; j++) begin
          pulse(j, fires(i, j, a != 0, a > 1));
        end
      end
    end
    // time protocol interrupt stays held until its status drains
    wr(5'h12, 16'h0008);
    pulse(4, 1'b0);
    rearm();
    pulse(4, 1'b1);
    pulse(4, 1'b0);
    host.access(1'b0, 5'h12, 16'h0000, rd, ak, ht);
    for (int s = 0; s < 4; s++) begin
      @(negedge clk_sys);
      spc_sel = 2'(s);
      pulse(1, 1'b0);
      rd_chk(5'h12, {7'h0, s == 0, 8'h08});
      pulse(0, 1'b0);
      rd_chk(5'h12, {7'h0, s != 0, 8'h08});
      rd_chk(5'h12, 16'h0008);
    end
    // mid-run reset with flag, enables, page and time protocol hold all non-default
    pulse(0, 1'b0);
    @(negedge clk_sys);
    rst = 1'b1;
    @(negedge clk_sys);
    rst = 1'b0;
    rd_chk(5'h12, 16'h0000);
    rd_chk(5'h13, 16'h0000);
    wr(5'h12, 16'h0008);
    pulse(4, 1'b1);
    report_and_stop();
  end

  initial begin
    #200us;
    err_count++;
    report_and_stop();
  end
endmodule : test_phy_event_enable_and_page_select
